// file: verilog/smfs_regs.v
// axi4-lite register slice: loop ratio report, snapshot, brownout and regulator control
// assumes reset-cause levels from the reset controller on aclk, analog status on async pins
`include "smfs_defs.vh"
`default_nettype none

module smfs_regs
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        rst_cause_por,
   input  wire        rst_cause_bod,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [15:0] live_ratio_error,
   input  wire [4:0]  live_ref_cycle_exponent,
   input  wire [7:0]  live_coarse,
   input  wire [8:0]  live_fine,
   input  wire        fuse_load_busy,
   input  wire        fuse_load_done,
   input  wire [1:0]  fuse_bod_mode,
   input  wire        fuse_bod_hysteresis_on,
   input  wire [5:0]  fuse_bod_level,
   input  wire [3:0]  fuse_trim_value,
   input  wire        low_power_sleep,
   input  wire        bod_irq_unmasked,
   input  wire        bod_trip_pin,
   input  wire        core_supply_level_pin,
   input  wire        input_supply_level_pin,
   input  wire        core_por_trip_pin,
   input  wire        input_por_trip_pin,
   input  wire        regulator_on_pin,
   input  wire        regulator_settled_pin,
   output wire        loop_enable,
   output wire        loop_closed,
   output wire [7:0]  loop_coarse,
   output wire [8:0]  loop_fine,
   output wire [1:0]  bod_mode,
   output wire        hysteresis_on,
   output wire [5:0]  bod_level,
   output wire        bod_reset_req,
   output wire        bod_irq_req,
   output wire        core_por_enable,
   output wire        input_por_enable,
   output wire        core_por_reset_req,
   output wire        input_por_reset_req,
   output wire        regulator_enable,
   output wire        regulator_deep,
   output wire [3:0]  trim_value,
   output wire        out_voltage_select,
   output wire        output_pulldown
);

   // byte-lane merge of a write onto the old register value
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      i;
      begin
         merge = old_v;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
   endfunction

   // offset match on the word address, low two bits ignored
   function hit;
      input [31:0] addr;
      input [5:0]  off;
      begin
         hit = (addr[31:6] == 26'h0) && (addr[5:2] == off[5:2]);
      end
   endfunction

   wire [`SMFS_NSYNC-1:0] pins_s;

   smfs_sync2 u_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({1'b0, bod_trip_pin, regulator_settled_pin, regulator_on_pin,
                  input_por_trip_pin, core_por_trip_pin, input_supply_level_pin,
                  core_supply_level_pin}),
      .sync_out (pins_s)
   );

   wire core_lvl_s = pins_s[0];
   wire in_lvl_s   = pins_s[1];
   wire core_trp_s = pins_s[2];
   wire in_trp_s   = pins_s[3];
   wire reg_on_s   = pins_s[4];
   wire settled_s  = pins_s[5];
   wire bod_trp_s  = pins_s[6];

   reg        awready_q;
   reg        wready_q;
   reg        aw_held_q;
   reg        w_held_q;
   reg [31:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   reg        bvalid_q;
   reg [1:0]  bresp_q;
   reg        arready_q;
   reg        rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0]  rresp_q;

   wire commit = aw_held_q && w_held_q && !bvalid_q;
   wire wr_ratio = commit && hit(awaddr_q, `SMFS_OFF_RATIO);
   wire wr_snap  = commit && hit(awaddr_q, `SMFS_OFF_SNAP);
   wire wr_bod   = commit && hit(awaddr_q, `SMFS_OFF_BOD);
   wire wr_vreg  = commit && hit(awaddr_q, `SMFS_OFF_VREG);
   wire wr_cfg   = commit && hit(awaddr_q, `SMFS_OFF_LOOPCFG);
   wire wr_stat  = commit && hit(awaddr_q, `SMFS_OFF_STATUS);
   wire wr_known = wr_ratio || wr_snap || wr_bod || wr_vreg || wr_cfg || wr_stat;

   // write channel: address and data taken in either order, one write at a time
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 32'h00000000;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `SMFS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && awready_q)
         begin
            awaddr_q  <= s_axi_awaddr;
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q)
         begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (commit)
         begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_known ? `SMFS_RESP_OKAY : `SMFS_RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   wire [31:0] wd_snap = merge(32'h00000000, wdata_q, wstrb_q);

   reg        loop_en_q;
   reg        loop_mode_q;
   reg [7:0]  coarse_q;
   reg [8:0]  fine_q;
   reg [15:0] ratio_snap_q;
   reg [4:0]  refexp_snap_q;
   reg [7:0]  coarse_snap_q;
   reg [8:0]  fine_snap_q;
   reg        snap_pend_q;
   reg        loop_ready_q;

   wire [31:0] cfg_rd = {(loop_mode_q ? coarse_snap_q : coarse_q), 7'h00,
                         (loop_mode_q ? fine_snap_q : fine_q), 6'h00, loop_mode_q, loop_en_q};
   wire [31:0] wd_cfg = merge(cfg_rd, wdata_q, wstrb_q);
   wire        snap_req = wr_snap && wd_snap[`SMFS_SNAP_BIT];

   // loop configuration and snapshot of the live loop values
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loop_en_q     <= 1'b0;
         loop_mode_q   <= 1'b0;
         coarse_q      <= 8'h00;
         fine_q        <= 9'h000;
         ratio_snap_q  <= 16'h0000;
         refexp_snap_q <= 5'h00;
         coarse_snap_q <= 8'h00;
         fine_snap_q   <= 9'h000;
         snap_pend_q   <= 1'b0;
         loop_ready_q  <= 1'b0;
      end
      else
      begin
         if (wr_cfg)
         begin
            loop_en_q   <= wd_cfg[`SMFS_LC_EN];
            loop_mode_q <= wd_cfg[`SMFS_LC_MODE];
            if (!loop_mode_q)
            begin
               coarse_q <= wd_cfg[`SMFS_LC_COAR_HI:`SMFS_LC_COAR_LO];
               fine_q   <= wd_cfg[`SMFS_LC_FINE_HI:`SMFS_LC_FINE_LO];
            end
         end
         // capture first, flag one cycle later is not needed: both land on the same edge
         if (snap_pend_q)
         begin
            ratio_snap_q  <= live_ratio_error;
            refexp_snap_q <= live_ref_cycle_exponent;
            coarse_snap_q <= live_coarse;
            fine_snap_q   <= live_fine;
         end
         snap_pend_q <= snap_req;
         // the setting capture wins over a clearing request in the same cycle
         if (snap_pend_q)
            loop_ready_q <= 1'b1;
         else if (snap_req)
            loop_ready_q <= 1'b0;
      end
   end

   reg       bod_lock_q;
   reg       bod_cal_q;
   reg [1:0] bod_mode_q;
   reg       bod_hysteresis_on_q;
   reg [5:0] bod_level_q;

   wire [31:0] bod_rd = {bod_lock_q, 14'h0000, bod_cal_q, 6'h00, bod_mode_q, 1'b0, bod_hysteresis_on_q, bod_level_q};
   wire [31:0] wd_bod = merge(bod_rd, wdata_q, wstrb_q);

   // brownout control; a brownout reset keeps lock, calibration and settings
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // power-on wins when both causes are flagged
         if (rst_cause_por || !rst_cause_bod)
         begin
            bod_lock_q  <= 1'b0;
            bod_cal_q   <= 1'b0;
            bod_mode_q  <= `SMFS_BOD_MODE_RST;
            bod_hysteresis_on_q  <= 1'b0;
            bod_level_q <= `SMFS_BOD_LVL_RST;
         end
      end
      else
      begin
         if (fuse_load_busy)
            bod_lock_q <= 1'b0;
         else if (wr_bod && !bod_lock_q)
         begin
            bod_lock_q  <= wd_bod[`SMFS_BOD_LOCK];
            bod_mode_q  <= wd_bod[`SMFS_BOD_MODE_HI:`SMFS_BOD_MODE_LO];
            bod_hysteresis_on_q  <= wd_bod[`SMFS_BOD_HYSTERESIS_ON];
            bod_level_q <= wd_bod[`SMFS_BOD_LVL_HI:`SMFS_BOD_LVL_LO];
         end
         // fuse values override a software write in the same cycle
         if (fuse_load_done && !bod_cal_q)
         begin
            bod_mode_q  <= fuse_bod_mode;
            bod_hysteresis_on_q  <= fuse_bod_hysteresis_on;
            bod_level_q <= fuse_bod_level;
            bod_cal_q   <= 1'b1;
         end
      end
   end

   reg       vr_lock_q;
   reg       vr_cal_q;
   reg       vr_en_q;
   reg       vr_sel_q;
   reg       vr_pd_q;
   reg       vr_nodeep_q;
   reg [3:0] vr_trim_q;
   reg       cpor_en_q;
   reg       ipor_en_q;
   reg       cpor_mask_q;
   reg       ipor_mask_q;

   // status bits are read from the pins or the enables and have no storage
   wire [31:0] vr_rd = {vr_lock_q, vr_pd_q, 4'h0, core_lvl_s, in_lvl_s,
                        cpor_mask_q, cpor_en_q, cpor_en_q, ipor_mask_q, ipor_en_q, ipor_en_q,
                        vr_nodeep_q, vr_cal_q, 4'h0, vr_trim_q,
                        reg_on_s, vr_en_q && settled_s, vr_en_q, 3'h0, vr_sel_q, 1'b0};
   wire [31:0] wd_vr = merge(vr_rd, wdata_q, wstrb_q);

   // regulator control; only a power-on reset touches it
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         if (rst_cause_por)
         begin
            vr_lock_q   <= 1'b0;
            vr_cal_q    <= 1'b0;
            vr_en_q     <= 1'b1;
            vr_sel_q    <= `SMFS_VR_SEL_RST;
            vr_pd_q     <= 1'b0;
            vr_nodeep_q <= 1'b0;
            vr_trim_q   <= `SMFS_VR_TRIM_RST;
            cpor_en_q   <= 1'b1;
            ipor_en_q   <= 1'b1;
            cpor_mask_q <= 1'b0;
            ipor_mask_q <= 1'b0;
         end
      end
      else
      begin
         if (wr_vreg && !vr_lock_q)
         begin
            vr_lock_q   <= wd_vr[`SMFS_VR_LOCK];
            vr_pd_q     <= wd_vr[`SMFS_VR_PD];
            cpor_mask_q <= wd_vr[`SMFS_VR_CMASK];
            ipor_mask_q <= wd_vr[`SMFS_VR_IMASK];
            cpor_en_q   <= wd_vr[`SMFS_VR_CEN];
            ipor_en_q   <= wd_vr[`SMFS_VR_IEN];
            vr_nodeep_q <= wd_vr[`SMFS_VR_NODEEP];
            vr_trim_q   <= wd_vr[`SMFS_VR_TRIM_HI:`SMFS_VR_TRIM_LO];
            vr_en_q     <= wd_vr[`SMFS_VR_EN];
            vr_sel_q    <= wd_vr[`SMFS_VR_SEL];
         end
         if (fuse_load_done && !vr_cal_q)
         begin
            vr_trim_q <= fuse_trim_value;
            vr_cal_q  <= 1'b1;
         end
      end
   end

   reg        bod_rst_q;
   reg        bod_irq_q;
   reg        cpor_rst_q;
   reg        ipor_rst_q;
   reg        deep_q;

   // derived controls, registered so every output leaves a flip-flop
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bod_rst_q  <= 1'b0;
         bod_irq_q  <= 1'b0;
         cpor_rst_q <= 1'b0;
         ipor_rst_q <= 1'b0;
         deep_q     <= 1'b0;
      end
      else
      begin
         bod_rst_q  <= bod_trp_s && (bod_mode_q == `SMFS_BOD_RESET);
         bod_irq_q  <= bod_trp_s && bod_irq_unmasked &&
                       ((bod_mode_q == `SMFS_BOD_RESET) || (bod_mode_q == `SMFS_BOD_IRQONLY));
         cpor_rst_q <= core_trp_s && cpor_en_q && !cpor_mask_q;
         ipor_rst_q <= in_trp_s && ipor_en_q && !ipor_mask_q;
         deep_q     <= low_power_sleep && !vr_nodeep_q;
      end
   end

   reg [31:0] rd_d;
   reg        rd_err_d;

   // read decode; the snapshot register is write-only and reads as zero
   always @*
   begin
      rd_d     = 32'h00000000;
      rd_err_d = 1'b0;
      if (hit(s_axi_araddr, `SMFS_OFF_RATIO))
         rd_d = {ratio_snap_q, 11'h000, refexp_snap_q};
      else if (hit(s_axi_araddr, `SMFS_OFF_SNAP))
         rd_d = 32'h00000000;
      else if (hit(s_axi_araddr, `SMFS_OFF_BOD))
         rd_d = bod_rd;
      else if (hit(s_axi_araddr, `SMFS_OFF_VREG))
         rd_d = vr_rd;
      else if (hit(s_axi_araddr, `SMFS_OFF_LOOPCFG))
         rd_d = cfg_rd;
      else if (hit(s_axi_araddr, `SMFS_OFF_STATUS))
      begin
         rd_d[`SMFS_ST_READY] = loop_ready_q;
         rd_d[`SMFS_ST_PEND]  = snap_pend_q;
      end
      else
         rd_err_d = 1'b1;
   end

   // read channel answers one cycle after the address is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `SMFS_RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_d;
         rresp_q   <= rd_err_d ? `SMFS_RESP_SLVERR : `SMFS_RESP_OKAY;
      end
      else if (rvalid_q && s_axi_rready)
      begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign s_axi_awready      = awready_q;
   assign s_axi_wready       = wready_q;
   assign s_axi_bvalid       = bvalid_q;
   assign s_axi_bresp        = bresp_q;
   assign s_axi_arready      = arready_q;
   assign s_axi_rvalid       = rvalid_q;
   assign s_axi_rdata        = rdata_q;
   assign s_axi_rresp        = rresp_q;
   assign loop_enable        = loop_en_q;
   assign loop_closed        = loop_mode_q;
   assign loop_coarse        = coarse_q;
   assign loop_fine          = fine_q;
   assign bod_mode           = bod_mode_q;
   assign hysteresis_on      = bod_hysteresis_on_q;
   assign bod_level          = bod_level_q;
   assign bod_reset_req      = bod_rst_q;
   assign bod_irq_req        = bod_irq_q;
   assign core_por_enable    = cpor_en_q;
   assign input_por_enable   = ipor_en_q;
   assign core_por_reset_req = cpor_rst_q;
   assign input_por_reset_req = ipor_rst_q;
   assign regulator_enable   = vr_en_q;
   assign regulator_deep     = deep_q;
   assign trim_value         = vr_trim_q;
   assign out_voltage_select = vr_sel_q;
   assign output_pulldown    = vr_pd_q;

endmodule

`default_nettype wire

// file: verilog/smfs_defs.vh
// constants for the supply monitor and loop status register slice
// assumes an axi4-lite master on aclk and reset-cause levels valid while aresetn is low
//
// Overview of operation
// - reference exponent field reports log2 measuring cycles
// - closed loop: upper half reports ratio error
// - snapshot copies values and sets ready flag on the same edge
// - brownout write lock makes register read-only
// - brownout lock cleared except brownout reset, calibration
// - brownout trim_value done kept on brownout reset
// - brownout mode: off, reset, irq-only, reserved
// - regulator lock, cleared only by power-on reset
// - two read-only supply level bits
// - por mask bit blocks detector reset output
// - enable bits switch por detectors on, off
// - por status bits report detector active
// - deep mode unless disabled during low-power sleep
// - regulator trim_value done cleared by power-on only
// - read-only regulator-on status bit
// - regulator good only when enabled and settled
// - power-on reset forces regulator enable
// - voltage select default means 1.8V output
// - loop mode bit one means closed loop
// - closed loop: coarse and fine read-only
`ifndef SMFS_DEFS_VH
`define SMFS_DEFS_VH

`define SMFS_OFF_RATIO    6'h00
`define SMFS_OFF_SNAP     6'h04
`define SMFS_OFF_BOD      6'h08
`define SMFS_OFF_VREG     6'h0C
`define SMFS_OFF_LOOPCFG  6'h10
`define SMFS_OFF_STATUS   6'h14

`define SMFS_RESP_OKAY    2'h0
`define SMFS_RESP_SLVERR  2'h2

`define SMFS_SNAP_BIT     0

`define SMFS_LC_EN        0
`define SMFS_LC_MODE      1
`define SMFS_LC_FINE_LO   8
`define SMFS_LC_FINE_HI   16
`define SMFS_LC_COAR_LO   24
`define SMFS_LC_COAR_HI   31

`define SMFS_BOD_LVL_LO   0
`define SMFS_BOD_LVL_HI   5
`define SMFS_BOD_HYSTERESIS_ON     6
`define SMFS_BOD_MODE_LO  8
`define SMFS_BOD_MODE_HI  9
`define SMFS_BOD_CAL      16
`define SMFS_BOD_LOCK     31
`define SMFS_BOD_OFF      2'h0
`define SMFS_BOD_RESET    2'h1
`define SMFS_BOD_IRQONLY  2'h2
`define SMFS_BOD_MODE_RST 2'h0
`define SMFS_BOD_LVL_RST  6'h00

`define SMFS_VR_SEL       1
`define SMFS_VR_EN        5
`define SMFS_VR_GOOD      6
`define SMFS_VR_ON        7
`define SMFS_VR_TRIM_LO   8
`define SMFS_VR_TRIM_HI   11
`define SMFS_VR_CAL       16
`define SMFS_VR_NODEEP    17
`define SMFS_VR_IEN       18
`define SMFS_VR_IACT      19
`define SMFS_VR_IMASK     20
`define SMFS_VR_CEN       21
`define SMFS_VR_CACT      22
`define SMFS_VR_CMASK     23
`define SMFS_VR_ILVL      24
`define SMFS_VR_CLVL      25
`define SMFS_VR_PD        30
`define SMFS_VR_LOCK      31
`define SMFS_VR_SEL_RST   1'b0
`define SMFS_VR_TRIM_RST  4'h0

`define SMFS_ST_READY     0
`define SMFS_ST_PEND      1

`define SMFS_NSYNC        8

`endif

// file: verilog/smfs_sync2.v
// two-stage synchroniser for asynchronous level inputs
// assumes levels change slowly compared with aclk
`include "smfs_defs.vh"
`default_nettype none

module smfs_sync2
(
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire [`SMFS_NSYNC-1:0] async_in,
   output wire [`SMFS_NSYNC-1:0] sync_out
);

   reg [`SMFS_NSYNC-1:0] meta_q;
   reg [`SMFS_NSYNC-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= {`SMFS_NSYNC{1'b0}};
         sync_q <= {`SMFS_NSYNC{1'b0}};
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

// file: bench/smfs_regs_monitor.sv
// concurrent checks on the ports of the register slice
// assumes it is bound to smfs_regs and that reset causes are steady while aresetn is low
`default_nettype none
module smfs_regs_monitor
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       rst_cause_por,
   input wire logic       rst_cause_bod,
   input wire logic       low_power_sleep,
   input wire logic       bod_irq_unmasked,
   input wire logic       loop_closed,
   input wire logic [7:0] loop_coarse,
   input wire logic [8:0] loop_fine,
   input wire logic [1:0] bod_mode,
   input wire logic [5:0] bod_level,
   input wire logic       bod_reset_req,
   input wire logic       bod_irq_req,
   input wire logic       core_por_enable,
   input wire logic       input_por_enable,
   input wire logic       core_por_reset_req,
   input wire logic       input_por_reset_req,
   input wire logic       regulator_enable,
   input wire logic       regulator_deep,
   input wire logic       out_voltage_select
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   bod_reset_mode_a: assert property ($past(aresetn) && bod_reset_req |-> $past(bod_mode) == 2'h1)
      else $error("brownout reset request outside reset mode");
   bod_irq_mode_a: assert property ($past(aresetn) && bod_irq_req
      |-> $past(bod_irq_unmasked) && $past(bod_mode) inside {2'h1, 2'h2})
      else $error("brownout irq request without enabled mode");
   core_por_req_a: assert property ($past(aresetn) && core_por_reset_req |-> $past(core_por_enable))
      else $error("core detector reset while disabled");
   input_por_req_a: assert property ($past(aresetn) && input_por_reset_req |-> $past(input_por_enable))
      else $error("input detector reset while disabled");
   deep_sleep_a: assert property ($past(aresetn) && regulator_deep |-> $past(low_power_sleep))
      else $error("deep mode outside low-power sleep");
   closed_hold_a: assert property ($past(aresetn) && $past(loop_closed)
      |-> $stable(loop_coarse) && $stable(loop_fine))
      else $error("calibration moved in closed loop");
   por_defaults_a: assert property (disable iff (1'b0) (!aresetn && rst_cause_por) ##1 aresetn
      |-> regulator_enable && core_por_enable && input_por_enable && !out_voltage_select)
      else $error("regulator defaults missing after power-on reset");
   bod_keep_a: assert property (disable iff (1'b0) !aresetn && rst_cause_bod && !rst_cause_por
      |=> bod_mode == $past(bod_mode) && bod_level == $past(bod_level))
      else $error("brownout fields lost on brownout reset");
   bod_clear_a: assert property (disable iff (1'b0) !aresetn && !rst_cause_bod && !rst_cause_por
      |=> bod_mode == 2'h0 && bod_level == 6'h00)
      else $error("brownout fields kept on other reset");
   cover property (bod_reset_req);
   cover property (core_por_reset_req);
   cover property (regulator_deep);
endmodule
bind smfs_regs smfs_regs_monitor smfs_regs_monitor_i (.*);
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench: axi4-lite accesses with expected register values
// assumes smfs_regs drives registered outputs and the monitor is bound beside it
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
   logic        aclk = 0, aresetn = 0, rst_cause_por = 1, rst_cause_bod = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp, bod_mode;
   wire logic [31:0] s_axi_rdata;
   logic [15:0] live_ratio_error = 16'h8001;
   logic [4:0]  live_ref_cycle_exponent = 5'h13;
   logic [7:0]  live_coarse = 8'h5A;
   logic [8:0]  live_fine = 9'h1C3;
   logic        fuse_load_busy = 0, fuse_load_done = 0, fuse_bod_hysteresis_on = 1;
   logic [1:0]  fuse_bod_mode = 2'h1;
   logic [5:0]  fuse_bod_level = 6'h15;
   logic [3:0]  fuse_trim_value = 4'hA;
   logic        low_power_sleep = 1, bod_irq_unmasked = 1, bod_trip_pin = 0, core_supply_level_pin = 1;
   logic        input_supply_level_pin = 0, core_por_trip_pin = 0, input_por_trip_pin = 0;
   logic        regulator_on_pin = 1, regulator_settled_pin = 1;
   wire logic   loop_enable, loop_closed, bod_reset_req, bod_irq_req, hysteresis_on, core_por_enable;
   wire logic   input_por_enable, core_por_reset_req, input_por_reset_req, regulator_enable, regulator_deep;
   wire logic   out_voltage_select, output_pulldown;
   wire logic [7:0] loop_coarse;
   wire logic [8:0] loop_fine;
   wire logic [5:0] bod_level;
   wire logic [3:0] trim_value;
   int          n_errors = 0, n_compared = 0;
   smfs_regs smfs_regs_i (.*);
   always #20 aclk = ~aclk;
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      `CHK("bresp", er, s_axi_bresp)
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      `CHK("rresp", er, s_axi_rresp)
      `CHK("rdata", e, s_axi_rdata & m)
   endtask
   // causes stay valid for the whole low phase; the slice samples them only then
   task automatic rst(input logic p, input logic b);
      @(posedge aclk);
      aresetn <= 0;
      rst_cause_por <= p;
      rst_cause_bod <= b;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rst_cause_por <= 0;
      rst_cause_bod <= 0;
      // pin synchronisers restart from zero and need two edges to refill
      repeat (2) @(posedge aclk);
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_errors++;
      end_sim;
   end
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      rst_cause_por <= 0;
      core_por_trip_pin <= 1;
      repeat (2) @(posedge aclk);
      rd(32'h0C, 32'h026C00E0, 32'hBFFFFFFF, 2'h0);
      rd(32'h08, 32'h0, 32'hFFFFFFFF, 2'h0);
      `CHK("core_por_reset_req", 1'b1, core_por_reset_req)
      `CHK("regulator_deep", 1'b1, regulator_deep)
      $display("test power-on defaults done");
      @(posedge aclk);
      fuse_load_done <= 1;
      @(posedge aclk);
      fuse_load_done <= 0;
      bod_trip_pin <= 1;
      rd(32'h08, 32'h00010155, 32'hFFFFFFFF, 2'h0);
      rd(32'h0C, 32'h026D0AE0, 32'hBFFFFFFF, 2'h0);
      `CHK("trim_value", 4'hA, trim_value)
      `CHK("hysteresis_on", 1'b1, hysteresis_on)
      for (int m = 0; m < 3; m++)
      begin
         wr(32'h08, {22'h0, m[1:0], 8'h55}, 2'h0);
         repeat (4) @(posedge aclk);
         `CHK("bod_reset_req", m == 1, bod_reset_req)
         `CHK("bod_irq_req", m != 0, bod_irq_req)
      end
      bod_irq_unmasked <= 0;
      repeat (3) @(posedge aclk);
      `CHK("bod_irq_req", 1'b0, bod_irq_req)
      bod_irq_unmasked <= 1;
      $display("test brownout modes done");
      wr(32'h08, 32'h80000255, 2'h0);
      wr(32'h08, 32'h0, 2'h0);
      rd(32'h08, 32'h80010255, 32'hFFFFFFFF, 2'h0);
      rst(1'b0, 1'b1);
      rd(32'h08, 32'h80010255, 32'hFFFFFFFF, 2'h0);
      @(posedge aclk);
      fuse_load_busy <= 1;
      @(posedge aclk);
      fuse_load_busy <= 0;
      rd(32'h08, 32'h00010255, 32'hFFFFFFFF, 2'h0);
      rst(1'b0, 1'b0);
      rd(32'h08, 32'h0, 32'hFFFFFFFF, 2'h0);
      rd(32'h0C, 32'h026D0AE0, 32'hBFFFFFFF, 2'h0);
      $display("test brownout lock done");
      input_por_trip_pin <= 1;
      wr(32'h0C, 32'hC1BA0A20, 2'h0);
      rd(32'h0C, 32'hC2F30AE0, 32'hFFFFFFFF, 2'h0);
      `CHK("output_pulldown", 1'b1, output_pulldown)
      `CHK("input_por_enable", 1'b0, input_por_enable)
      `CHK("core_por_reset_req", 1'b0, core_por_reset_req)
      `CHK("input_por_reset_req", 1'b0, input_por_reset_req)
      `CHK("regulator_deep", 1'b0, regulator_deep)
      wr(32'h0C, 32'h0, 2'h0);
      rst(1'b0, 1'b0);
      rd(32'h0C, 32'hC2F30AE0, 32'hFFFFFFFF, 2'h0);
      regulator_settled_pin <= 0;
      rst(1'b1, 1'b0);
      rd(32'h0C, 32'h026C00A0, 32'hFFFFFFFF, 2'h0);
      `CHK("regulator_enable", 1'b1, regulator_enable)
      `CHK("out_voltage_select", 1'b0, out_voltage_select)
      $display("test regulator done");
      rd(32'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
      wr(32'h10, 32'h3300A503, 2'h0);
      wr(32'h10, 32'h7700FF03, 2'h0);
      `CHK("loop_coarse", 8'h33, loop_coarse)
      `CHK("loop_closed", 1'b1, loop_closed)
      `CHK("loop_enable", 1'b1, loop_enable)
      wr(32'h04, 32'h1, 2'h0);
      rd(32'h14, 32'h1, 32'h3, 2'h0);
      rd(32'h00, 32'h80010013, 32'hFFFFFFFF, 2'h0);
      rd(32'h10, 32'h5A01C303, 32'hFFFFFFFF, 2'h0);
      rd(32'h04, 32'h0, 32'hFFFFFFFF, 2'h0);
      rd(32'h18, 32'h0, 32'hFFFFFFFF, 2'h2);
      wr(32'h18, 32'h1, 2'h2);
      $display("test loop snapshot done");
      end_sim;
   end
endmodule
`default_nettype wire
